// file: hdl/lga_pkg.sv
// package: attribute map, service codes and carrier types of the light grid attribute bank
package lga_pkg;

  // service codes
  localparam logic [7:0] SVC_GET = 8'h0e;
  localparam logic [7:0] SVC_SET = 8'h10;

  // attribute classes
  localparam logic [7:0] CLS_CONFIG = 8'h65;
  localparam logic [7:0] CLS_AUX    = 8'h66;

  // configuration class attributes
  localparam logic [7:0] ATTR_STANDBY_ENABLE    = 8'h05;
  localparam logic [7:0] ATTR_OFF_DELAY_OUTPUT1 = 8'h06;
  localparam logic [7:0] ATTR_OFF_DELAY_OUTPUT4 = 8'h09;
  localparam logic [7:0] ATTR_OFF_DELAY_SHARED  = 8'h0a;

  // auxiliary class attributes
  localparam logic [7:0] ATTR_ALIGN_AID_ENABLE  = 8'h01;
  localparam logic [7:0] ATTR_ALIGN_VALUES      = 8'h02;
  localparam logic [7:0] ATTR_LOCATOR_FLASH     = 8'h03;
  localparam logic [7:0] ATTR_TEACH_BUTTON_LOCK = 8'h04;
  localparam logic [7:0] ATTR_BEAM_NUMBERING    = 8'h05;
  localparam logic [7:0] ATTR_UPLOAD_TRIGGER    = 8'h06;
  localparam logic [7:0] ATTR_CLONE_STATE       = 8'h08;

  // answer status codes
  localparam logic [7:0] ST_SUCCESS       = 8'h00;
  localparam logic [7:0] ST_NO_SERVICE    = 8'h08;
  localparam logic [7:0] ST_BAD_VALUE     = 8'h09;
  localparam logic [7:0] ST_NOT_SETTABLE  = 8'h0e;
  localparam logic [7:0] ST_NO_ATTRIBUTE  = 8'h14;

  // reset values
  localparam logic        RST_BOOL  = 1'b0;
  localparam logic [15:0] RST_DELAY = 16'h0000;

  // field layout and limits
  localparam int          OUTPUTS       = 16;
  localparam int          OWN_DELAYS    = 4;
  localparam logic [7:0]  SIGNAL_FULL   = 8'h64;
  localparam logic [7:0]  BOOL_MAX      = 8'h01;

  // timing: switch-off delay counts in milliseconds
  localparam int DELAY_UNIT_NS = 1000000;
  localparam int CLOCK_NS      = 25;
  localparam int TICK_CYCLES   = DELAY_UNIT_NS / CLOCK_NS;
  localparam int FLASH_MS      = 250;

  typedef enum logic [7:0] {
    CLONE_LOCKED, CLONE_EMPTY, CLONE_VALID, CLONE_ACTIVE
  } lga_clone_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  service;
    logic [7:0]  cls;
    logic [7:0]  attr;
    logic [23:0] data;
  } lga_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  status;
    logic [23:0] data;
  } lga_rsp_t;

  typedef struct packed {
    logic [7:0] worst;
    logic [7:0] end_cap;
    logic [7:0] connector;
  } lga_align_t;

endpackage : lga_pkg

// file: hdl/lga_attr_bank.sv
// module: attribute bank with standby, switch-off delays, alignment, locator and upload
`timescale 1ns/100ps

module lga_attr_bank
  import lga_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int BEAMS         = 16
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_RST_N,
  input  wire lga_req_t         I_REQ,
  output lga_rsp_t              O_RSP,
  input  wire logic [OUTPUTS-1:0] I_RAW_OUTPUTS,
  output logic [OUTPUTS-1:0]    O_SWITCH_OUTPUTS,
  output logic [OUTPUTS-1:0]    O_OUTPUT_STATE_WORD,
  output logic                  O_STANDBY,
  output logic                  O_ALIGN_AID,
  input  wire lga_align_t       I_ALIGN_VALUES,
  output logic [2:0]            O_RX_LEDS,
  input  wire logic             I_TEACH_BUTTON,
  output logic                  O_TEACH_PRESS,
  input  wire logic [BEAMS-1:0] I_BEAM_STATUS,
  output logic [BEAMS-1:0]      O_BEAM_STATUS,
  output logic                  O_NUMBERING_REVERSE,
  output logic                  O_UPLOAD_START,
  input  wire lga_clone_state_t I_CLONE_STATE
);

  localparam int FLASH_TICKS = FLASH_MS;

  // off delay that governs a given output
  function automatic logic [15:0] delay_for(input int idx,
                                            input logic [15:0] own [OWN_DELAYS],
                                            input logic [15:0] shared);
    delay_for = (idx < OWN_DELAYS) ? own[idx] : shared;
  endfunction : delay_for

  // percent byte limited to full scale
  function automatic logic [7:0] pct(input logic [7:0] v);
    pct = (v > SIGNAL_FULL) ? SIGNAL_FULL : v;
  endfunction : pct

  logic [15:0]         delay_own_q [OWN_DELAYS];
  logic [15:0]         delay_shared_q;
  logic                standby_q;
  logic                align_aid_q;
  logic                locator_q;
  logic                button_lock_q;
  logic                reverse_q;
  logic                upload_q;
  lga_align_t          align_q;
  lga_rsp_t            rsp_q;
  logic [15:0]         hold_cnt_q [OUTPUTS];
  logic [OUTPUTS-1:0]  out_q;
  logic [31:0]         tick_cnt_q;
  logic                tick;
  logic [15:0]         flash_cnt_q;
  logic [2:0]          leds_q;
  logic                button_prev_q;
  logic                press_q;
  logic                upload_start_q;
  logic [BEAMS-1:0]    beam_q;
  logic [OUTPUTS-1:0]  delayed_d;

  logic                is_get;
  logic                is_set;
  logic                hit_cfg;
  logic                hit_aux;
  logic                bool_ok;
  logic [7:0]          status_d;
  logic [23:0]         rdata_d;

  assign is_get  = I_REQ.valid && (I_REQ.service == SVC_GET);
  assign is_set  = I_REQ.valid && (I_REQ.service == SVC_SET);
  assign hit_cfg = I_REQ.cls == CLS_CONFIG;
  assign hit_aux = I_REQ.cls == CLS_AUX;
  assign bool_ok = I_REQ.data <= {16'h0000, BOOL_MAX};

  // answer decode: status and read data for the request in hand
  always_comb begin
    status_d = ST_NO_ATTRIBUTE;
    rdata_d  = '0;
    if (!is_get && !is_set) begin
      status_d = ST_NO_SERVICE;
    end else if (hit_cfg) begin
      if (I_REQ.attr == ATTR_STANDBY_ENABLE) begin
        status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
        rdata_d  = {23'h0, standby_q};
      end else if (I_REQ.attr >= ATTR_OFF_DELAY_OUTPUT1 &&
                   I_REQ.attr <= ATTR_OFF_DELAY_SHARED) begin
        status_d = ST_SUCCESS;
        if (I_REQ.attr == ATTR_OFF_DELAY_SHARED) begin
          rdata_d = {8'h00, delay_shared_q};
        end else begin
          rdata_d = {8'h00, delay_own_q[2'(I_REQ.attr - ATTR_OFF_DELAY_OUTPUT1)]};
        end
      end
    end else if (hit_aux) begin
      case (I_REQ.attr)
        ATTR_ALIGN_AID_ENABLE: begin
          status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
          rdata_d  = {23'h0, align_aid_q};
        end
        ATTR_ALIGN_VALUES: begin
          status_d = is_set ? ST_NOT_SETTABLE : ST_SUCCESS;
          rdata_d  = align_q;
        end
        ATTR_LOCATOR_FLASH: begin
          status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
          rdata_d  = {23'h0, locator_q};
        end
        ATTR_TEACH_BUTTON_LOCK: begin
          status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
          rdata_d  = {23'h0, button_lock_q};
        end
        ATTR_BEAM_NUMBERING: begin
          status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
          rdata_d  = {23'h0, reverse_q};
        end
        ATTR_UPLOAD_TRIGGER: begin
          status_d = (is_set && !bool_ok) ? ST_BAD_VALUE : ST_SUCCESS;
          rdata_d  = {23'h0, upload_q};
        end
        ATTR_CLONE_STATE: begin
          status_d = is_set ? ST_NOT_SETTABLE : ST_SUCCESS;
          rdata_d  = {16'h0000, 8'(I_CLONE_STATE)};
        end
        default: begin
          status_d = ST_NO_ATTRIBUTE;
          rdata_d  = '0;
        end
      endcase
    end
  end

  logic wr_ok;
  assign wr_ok = is_set && (status_d == ST_SUCCESS);

  // answer one cycle after each request
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid  <= I_REQ.valid;
      rsp_q.status <= status_d;
      rsp_q.data   <= is_get ? rdata_d : '0;
    end
  end

  // configuration class storage
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      standby_q      <= RST_BOOL;
      delay_shared_q <= RST_DELAY;
      for (int i = 0; i < OWN_DELAYS; i++) begin
        delay_own_q[i] <= RST_DELAY;
      end
    end else if (wr_ok && hit_cfg) begin
      if (I_REQ.attr == ATTR_STANDBY_ENABLE) begin
        standby_q <= I_REQ.data[0];
      end else if (I_REQ.attr == ATTR_OFF_DELAY_SHARED) begin
        delay_shared_q <= I_REQ.data[15:0];
      end else begin
        delay_own_q[2'(I_REQ.attr - ATTR_OFF_DELAY_OUTPUT1)] <= I_REQ.data[15:0];
      end
    end
  end

  // auxiliary class storage; reversed numbering off means beam one at connector
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      align_aid_q   <= RST_BOOL;
      locator_q     <= RST_BOOL;
      button_lock_q <= RST_BOOL;
      reverse_q     <= RST_BOOL;
      upload_q      <= RST_BOOL;
    end else if (wr_ok && hit_aux) begin
      case (I_REQ.attr)
        ATTR_ALIGN_AID_ENABLE:  align_aid_q   <= I_REQ.data[0];
        ATTR_LOCATOR_FLASH:     locator_q     <= I_REQ.data[0];
        ATTR_TEACH_BUTTON_LOCK: button_lock_q <= I_REQ.data[0];
        ATTR_BEAM_NUMBERING:    reverse_q     <= I_REQ.data[0];
        ATTR_UPLOAD_TRIGGER:    upload_q      <= I_REQ.data[0];
        default:                upload_q      <= upload_q;
      endcase
    end
  end

  // upload starts on the rising write only; rewriting 1 does nothing
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      upload_start_q <= 1'b0;
    end else begin
      upload_start_q <= wr_ok && hit_aux && (I_REQ.attr == ATTR_UPLOAD_TRIGGER) &&
                        I_REQ.data[0] && !upload_q;
    end
  end

  // signal record is refreshed only from the measurement side, never by a set
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      align_q <= '0;
    end else begin
      align_q.connector <= pct(I_ALIGN_VALUES.connector);
      align_q.end_cap   <= pct(I_ALIGN_VALUES.end_cap);
      align_q.worst     <= pct(I_ALIGN_VALUES.worst);
    end
  end

  // millisecond tick shared by the off delays and the locator flash
  assign tick = tick_cnt_q == 32'(TICK_CYCLES_P - 1);

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // off delay: a falling output stays on for the configured milliseconds
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      for (int i = 0; i < OUTPUTS; i++) begin
        hold_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < OUTPUTS; i++) begin
        if (I_RAW_OUTPUTS[i]) begin
          hold_cnt_q[i] <= delay_for(i, delay_own_q, delay_shared_q);
        end else if (tick && hold_cnt_q[i] != '0) begin
          hold_cnt_q[i] <= hold_cnt_q[i] - 16'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < OUTPUTS; i++) begin
      delayed_d[i] = I_RAW_OUTPUTS[i] || (hold_cnt_q[i] != '0);
    end
  end

  // standby freezes pins and state word alike; delays keep counting underneath
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      out_q <= '0;
    end else if (!standby_q) begin
      out_q <= delayed_d;
    end
  end

  // locator flash: all three leds together at a fixed blink rate
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      flash_cnt_q <= '0;
      leds_q      <= '0;
    end else if (!locator_q) begin
      flash_cnt_q <= '0;
      leds_q      <= '0;
    end else if (tick) begin
      if (flash_cnt_q == 16'(FLASH_TICKS - 1)) begin
        flash_cnt_q <= '0;
        leds_q      <= ~leds_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 16'h1;
      end
    end
  end

  // teach press pulse on the button's rising edge unless locked
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      button_prev_q <= 1'b0;
      press_q       <= 1'b0;
    end else begin
      button_prev_q <= I_TEACH_BUTTON;
      press_q       <= I_TEACH_BUTTON && !button_prev_q && !button_lock_q;
    end
  end

  // per-beam status mirrored when numbering starts at the head
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      beam_q <= '0;
    end else begin
      for (int b = 0; b < BEAMS; b++) begin
        beam_q[b] <= reverse_q ? I_BEAM_STATUS[BEAMS-1-b] : I_BEAM_STATUS[b];
      end
    end
  end

  assign O_RSP               = rsp_q;
  assign O_SWITCH_OUTPUTS    = out_q;
  assign O_OUTPUT_STATE_WORD = out_q;
  assign O_STANDBY           = standby_q;
  assign O_ALIGN_AID         = align_aid_q;
  assign O_RX_LEDS           = leds_q;
  assign O_TEACH_PRESS       = press_q;
  assign O_BEAM_STATUS       = beam_q;
  assign O_NUMBERING_REVERSE = reverse_q;
  assign O_UPLOAD_START      = upload_start_q;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_set_aux(logic [7:0] a);
    is_set && hit_aux && I_REQ.attr == a;
  endsequence

  a_rsp_latency: assert property (I_REQ.valid |=> O_RSP.valid)
    else $error("answer missing one cycle after request");
  a_bad_service: assert property (I_REQ.valid && !is_get && !is_set
                                  |=> O_RSP.status == ST_NO_SERVICE)
    else $error("unknown service not refused");
  a_standby_set: assert property (is_set && hit_cfg && I_REQ.attr == ATTR_STANDBY_ENABLE &&
                                  I_REQ.data == 24'h1 |=> O_STANDBY)
    else $error("standby did not engage");
  a_standby_hold: assert property (O_STANDBY && $past(O_STANDBY)
                                   |-> $stable(O_SWITCH_OUTPUTS))
    else $error("outputs moved during standby");
  a_state_word: assert property (O_OUTPUT_STATE_WORD == O_SWITCH_OUTPUTS)
    else $error("state word differs from delayed outputs");
  a_ro_reject: assert property (s_set_aux(ATTR_ALIGN_VALUES)
                                |=> O_RSP.status == ST_NOT_SETTABLE)
    else $error("set on signal record accepted");
  a_pct_limit: assert property (align_q.connector <= SIGNAL_FULL &&
                                align_q.end_cap <= SIGNAL_FULL &&
                                align_q.worst <= SIGNAL_FULL)
    else $error("signal byte above full scale");
  a_locator_off: assert property (!locator_q |=> O_RX_LEDS == 3'h0)
    else $error("leds flash with locator off");
  a_button_lock: assert property (button_lock_q && $past(button_lock_q)
                                  |-> !O_TEACH_PRESS)
    else $error("locked button still acted");
  a_beam_order: assert property (reverse_q
                                 |=> O_BEAM_STATUS[0] == $past(I_BEAM_STATUS[BEAMS-1]))
    else $error("reversed numbering not applied");
  a_upload_edge: assert property (s_set_aux(ATTR_UPLOAD_TRIGGER) && wr_ok && upload_q
                                  |=> !O_UPLOAD_START)
    else $error("upload started on a level");
  a_upload_rise: assert property (s_set_aux(ATTR_UPLOAD_TRIGGER) && wr_ok && !upload_q &&
                                  I_REQ.data == 24'h1
                                  |=> O_UPLOAD_START ##1 !O_UPLOAD_START)
    else $error("upload start not a single pulse");

endmodule : lga_attr_bank

// file: testbench/lga_ctrl_model.sv
// fieldbus controller model: attribute requests and stored-parameter state
`timescale 1ns/100ps
module lga_ctrl_model
  import lga_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_upload_start,
  output lga_req_t         o_req,
  output lga_clone_state_t o_clone
);
  int cnt = 0;
  initial o_req = '0;
  initial o_clone = CLONE_EMPTY;
  // one request, then released with inverted fields so stale values never match
  task automatic send(input logic [7:0] sv, c, a, input logic [23:0] d);
    o_req = '{1'b1, sv, c, a, d};
    @(posedge i_clk);
    #2 o_req = '{1'b0, ~sv, ~c, ~a, ~d};
    @(posedge i_clk);
    #2;
  endtask : send
  // a repeated upload needs the 0 written first
  task automatic upload();
    send(SVC_SET, CLS_AUX, ATTR_UPLOAD_TRIGGER, 24'h0);
    send(SVC_SET, CLS_AUX, ATTR_UPLOAD_TRIGGER, 24'h1);
  endtask : upload
  // stored-parameter state: busy for a few cycles after each upload
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_clone <= CLONE_EMPTY;
      cnt <= 0;
    end else if (i_upload_start) begin
      o_clone <= CLONE_ACTIVE;
      cnt <= 8;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) o_clone <= CLONE_VALID;
    end
  end
endmodule : lga_ctrl_model

// file: testbench/tb.sv
// testbench: attribute services, switch-off delays, standby, locator, teach lock, upload
`timescale 1ns/100ps
module tb;
  import lga_pkg::*;
  localparam int TK = 4;
  logic             I_CLOCK = 1'b0;
  logic             I_RST_N = 1'b0;
  lga_req_t         req;
  lga_rsp_t         rsp;
  logic [15:0]      raw = 16'h0;
  logic [15:0]      sw, qs, bout, br;
  logic [15:0]      bin = 16'h0;
  logic             stby, aid, rev, tpress, upst;
  logic             btn = 1'b0;
  lga_align_t       alv = '0;
  logic [2:0]       leds;
  lga_clone_state_t cst;
  logic [31:0]      exp_q[$];
  logic [31:0]      seed = 32'h927f;
  logic [15:0]      bools [4] = '{16'h6505, 16'h6601, 16'h6604, 16'h6605};
  int               err_total = 0, compares = 0, up_n = 0, press_n = 0;

  lga_attr_bank #(.TICK_CYCLES_P(TK), .BEAMS(16)) u_dut (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_REQ(req), .O_RSP(rsp),
    .I_RAW_OUTPUTS(raw), .O_SWITCH_OUTPUTS(sw), .O_OUTPUT_STATE_WORD(qs),
    .O_STANDBY(stby), .O_ALIGN_AID(aid), .I_ALIGN_VALUES(alv), .O_RX_LEDS(leds),
    .I_TEACH_BUTTON(btn), .O_TEACH_PRESS(tpress), .I_BEAM_STATUS(bin),
    .O_BEAM_STATUS(bout), .O_NUMBERING_REVERSE(rev), .O_UPLOAD_START(upst),
    .I_CLONE_STATE(cst));
  lga_ctrl_model u_ctrl (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_upload_start(upst),
    .o_req(req), .o_clone(cst));

  initial begin
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end

  task automatic end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp_lvl(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_lvl
  task automatic cmp_rsp(input logic [31:0] e, input logic [31:0] g);
    cmp_lvl("response", e, g);
  endtask : cmp_rsp
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLOCK);
    #2;
  endtask : cyc
  task automatic rnd(output logic [31:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed;
  endtask : rnd
  // the expectation is noted before the request leaves
  task automatic rq(input logic [7:0] sv, c, a, input logic [23:0] d,
                    input logic [7:0] es, input logic [23:0] ed);
    exp_q.push_back({es, ed});
    u_ctrl.send(sv, c, a, d);
  endtask : rq
  task automatic rd(input logic [7:0] c, a, input logic [23:0] ed);
    rq(SVC_GET, c, a, 24'h0, ST_SUCCESS, ed);
  endtask : rd
  task automatic wr(input logic [7:0] c, a, input logic [23:0] d);
    rq(SVC_SET, c, a, d, ST_SUCCESS, 24'h0);
  endtask : wr
  task automatic chk_out(input logic [15:0] e);
    cmp_lvl("switch outputs", {16'h0, e}, {16'h0, sw});
    cmp_lvl("state word", {16'h0, e}, {16'h0, qs});
  endtask : chk_out

  // watcher: answers against the oldest note, pulses counted
  always @(posedge I_CLOCK) begin
    #1;
    up_n += int'(upst === 1'b1);
    press_n += int'(tpress === 1'b1);
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("CHECK FAILED response expected none seen %h", rsp);
      end else begin
        cmp_rsp(exp_q.pop_front(), {rsp.status, rsp.data});
      end
    end
  end

  initial begin
    repeat (100000) @(posedge I_CLOCK);
    err_total++;
    end_of_test();
  end

  initial begin
    logic [31:0] v;
    logic [15:0] dl [5];
    repeat (10) @(posedge I_CLOCK);
    #2 I_RST_N = 1'b1;
    for (int i = 0; i < 4; i++) rd(bools[i][15:8], bools[i][7:0], 24'h0);
    rd(CLS_AUX, ATTR_LOCATOR_FLASH, 24'h0);
    rd(CLS_AUX, ATTR_UPLOAD_TRIGGER, 24'h0);
    for (int i = 0; i < 5; i++) rd(CLS_CONFIG, ATTR_OFF_DELAY_OUTPUT1 + 8'(i), 24'h0);
    for (int b = 1; b >= 0; b--) begin
      for (int i = 0; i < 4; i++) begin
        wr(bools[i][15:8], bools[i][7:0], 24'(b));
        rd(bools[i][15:8], bools[i][7:0], 24'(b));
      end
      cyc(2);
      cmp_lvl("mode levels", {29'h0, {3{1'(b)}}}, {29'h0, stby, aid, rev});
    end
    for (int i = 0; i < 5; i++) begin
      rnd(v);
      dl[i] = v[15:0];
      wr(CLS_CONFIG, ATTR_OFF_DELAY_OUTPUT1 + 8'(i), {8'h0, dl[i]});
    end
    for (int i = 0; i < 5; i++) begin
      rd(CLS_CONFIG, ATTR_OFF_DELAY_OUTPUT1 + 8'(i), {8'h0, dl[i]});
    end
    rq(8'h0f, CLS_AUX, ATTR_ALIGN_AID_ENABLE, 24'h1, ST_NO_SERVICE, 24'h0);
    rq(SVC_GET, CLS_AUX, 8'h09, 24'h0, ST_NO_ATTRIBUTE, 24'h0);
    rq(SVC_SET, CLS_AUX, ATTR_CLONE_STATE, 24'h1, ST_NOT_SETTABLE, 24'h0);
    rq(SVC_SET, CLS_AUX, ATTR_LOCATOR_FLASH, 24'h2, ST_BAD_VALUE, 24'h0);
    rd(CLS_AUX, ATTR_LOCATOR_FLASH, 24'h0);
    rnd(v);
    alv = {v[23:16] % 8'd101, 8'd0, SIGNAL_FULL};
    cyc(2);
    rd(CLS_AUX, ATTR_ALIGN_VALUES, alv);
    rq(SVC_SET, CLS_AUX, ATTR_ALIGN_VALUES, ~alv, ST_NOT_SETTABLE, 24'h0);
    rd(CLS_AUX, ATTR_ALIGN_VALUES, alv);
    for (int s = 0; s < 4; s++) begin
      u_ctrl.o_clone = lga_clone_state_t'(s);
      cyc(2);
      rd(CLS_AUX, ATTR_CLONE_STATE, 24'(s));
    end
    wr(CLS_AUX, ATTR_UPLOAD_TRIGGER, 24'h1);
    wr(CLS_AUX, ATTR_UPLOAD_TRIGGER, 24'h1);
    cmp_lvl("upload starts", 32'd1, up_n);
    exp_q.push_back({ST_SUCCESS, 24'h0});
    exp_q.push_back({ST_SUCCESS, 24'h0});
    u_ctrl.upload();
    cmp_lvl("upload starts", 32'd2, up_n);
    wr(CLS_CONFIG, ATTR_OFF_DELAY_OUTPUT1, 24'd5);
    wr(CLS_CONFIG, ATTR_OFF_DELAY_OUTPUT1 + 8'd1, 24'd0);
    wr(CLS_CONFIG, ATTR_OFF_DELAY_SHARED, 24'd2);
    raw = 16'h0013;
    cyc(3);
    chk_out(16'h0013);
    raw = 16'h0000;
    cyc(3);
    chk_out(16'h0011);
    cyc(10);
    chk_out(16'h0001);
    cyc(20);
    chk_out(16'h0000);
    raw = 16'h8000;
    cyc(3);
    wr(CLS_CONFIG, ATTR_STANDBY_ENABLE, 24'h1);
    cyc(1);
    raw = 16'h0100;
    cyc(30);
    chk_out(16'h8000);
    wr(CLS_CONFIG, ATTR_STANDBY_ENABLE, 24'h0);
    cyc(3);
    chk_out(16'h0100);
    raw = 16'h0000;
    rnd(v);
    bin = v[15:0];
    br = {<<{v[15:0]}};
    cyc(3);
    cmp_lvl("beam status", {16'h0, bin}, {16'h0, bout});
    wr(CLS_AUX, ATTR_BEAM_NUMBERING, 24'h1);
    cyc(2);
    cmp_lvl("beam status", {16'h0, br}, {16'h0, bout});
    wr(CLS_AUX, ATTR_BEAM_NUMBERING, 24'h0);
    for (int l = 0; l < 2; l++) begin
      wr(CLS_AUX, ATTR_TEACH_BUTTON_LOCK, 24'(l));
      press_n = 0;
      btn = 1'b1;
      cyc(4);
      btn = 1'b0;
      cyc(2);
      cmp_lvl("teach presses", 32'(1 - l), press_n);
    end
    // bounded wait: one toggle is 250 ticks
    wr(CLS_AUX, ATTR_LOCATOR_FLASH, 24'h1);
    for (int n = 0; n < 1100 && leds !== 3'b111; n++) cyc(1);
    cmp_lvl("receiver leds", 32'h7, {29'h0, leds});
    wr(CLS_AUX, ATTR_LOCATOR_FLASH, 24'h0);
    cyc(2);
    cmp_lvl("receiver leds", 32'h0, {29'h0, leds});
    cyc(4);
    cmp_lvl("pending answers", 32'h0, exp_q.size());
    end_of_test();
  end
endmodule : tb
